// ==== hw/wch_pkg.sv ====
// Constants and carrier types for the waveform capture and harmonic analyser
package wch_pkg;
  // ==========================================
  // Channels
  localparam int NUM_CHAN = 18;
  localparam int CH_W = 5;
  localparam logic [4:0] CH_FIRST = 5'h00;
  localparam logic [4:0] CH_MAINS_I1 = 5'h06;
  localparam logic [4:0] CH_GEN_V1 = 5'h09;
  localparam logic [4:0] CH_LAST = 5'(NUM_CHAN - 1);
  // ==========================================
  // Capture
  localparam int SMP_W = 13;
  localparam int DISP_LEN = 100;
  localparam int ANA_LEN = 1024;
  localparam int SMP_RATE_HZ = 4096;
  localparam int UPDATE_HZ = 2;
  localparam int UPDATE_SMP = SMP_RATE_HZ / UPDATE_HZ;
  localparam int CNT_W = 11;
  localparam int DA_W = 7;
  localparam int AA_W = 10;
  localparam logic [11:0] FULL_SCALE = 12'hFFF;
  // ==========================================
  // Harmonics
  localparam int MAX_ORDER = 31;
  localparam int MAX_HARM_HZ = 1800;
  localparam int F0_W = 11;
  localparam int HA_W = 5;
  localparam int PML_W = 11;
  localparam logic [10:0] PML_FULL = 11'h3E8;
  localparam logic [10:0] SHOW_MIN_PML = 11'h014;
  localparam int COEF_FRAC = 14;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic vld;
    logic signed [SMP_W-1:0] data;
  } wch_smp_s;
  typedef struct packed {
    logic valid;
    logic show;
    logic [PML_W-1:0] pml;
  } wch_harm_s;
endpackage

// ==== hw/wch_harmonic.sv ====
// Per-harmonic spectral analysis of one captured frame
`timescale 1ns/1ps
module wch_harmonic (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Control
  input wire logic start_i,
  input wire logic [wch_pkg::F0_W-1:0] f0_i,
  output logic busy_o,
  output logic done_o,
  // Frame read
  output logic [wch_pkg::AA_W-1:0] rd_addr_o,
  input wire logic signed [wch_pkg::SMP_W-1:0] rd_data_i,
  // Results
  output logic res_we_o,
  output logic [wch_pkg::HA_W-1:0] res_order_o,
  output logic [wch_pkg::PML_W-1:0] res_pml_o
);
  import wch_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_COEF, S_RUN, S_PWR, S_SQRT, S_DIV} wch_hst_e;

  // ==========================================
  // Helpers
  function automatic logic ord_ok(input logic [4:0] h, input logic [10:0] f);
    return h != 5'h00 && 32'(h) <= MAX_ORDER && 32'(h) * 32'(f) <= MAX_HARM_HZ;
  endfunction

  // Bin angle step of a 1024-point frame, in units of 2^-30 rad
  localparam int ANG_FRAC = 30;
  localparam longint ANG_ONE = 64'sh40000000;
  localparam longint ANG_STEP = 64'sh6487ED;

  // Cosine folded to one quadrant, six-term series (divisors 90, 56, 30, 12, 2).
  // A coarse fit pulls the filter off its bin and skews every ratio.
  function automatic logic signed [17:0] wch_coef(input logic [9:0] k);
    int m;
    logic neg;
    longint ang;
    longint z;
    longint t;
    m = (int'(k) > ANA_LEN / 2) ? ANA_LEN - int'(k) : int'(k);
    neg = m > ANA_LEN / 4;
    if (neg) begin
      m = ANA_LEN / 2 - m;
    end
    ang = longint'(m) * ANG_STEP;
    z = (ang * ang) >>> ANG_FRAC;
    t = ANG_ONE;
    t = ANG_ONE - ((z * t) >>> ANG_FRAC) / 64'sh5A;
    t = ANG_ONE - ((z * t) >>> ANG_FRAC) / 64'sh38;
    t = ANG_ONE - ((z * t) >>> ANG_FRAC) / 64'sh1E;
    t = ANG_ONE - ((z * t) >>> ANG_FRAC) / 64'sh0C;
    t = ANG_ONE - ((z * t) >>> ANG_FRAC) / 64'sh02;
    t = (t + (ANG_ONE >>> (COEF_FRAC + 2))) >>> (ANG_FRAC - COEF_FRAC - 1);
    return neg ? -18'(t) : 18'(t);
  endfunction

  // ==========================================
  // Datapath
  wch_hst_e st_reg;
  logic [4:0] h_reg, ord_reg;
  logic [10:0] f0_reg, n_reg, q_reg, pml_reg;
  logic [5:0] bit_reg;
  logic signed [17:0] coef_reg;
  logic signed [39:0] s1_reg, s2_reg;
  logic [63:0] pw_reg;
  logic [31:0] root_reg, mag1_reg;
  logic we_reg, done_reg;

  logic [31:0] bin_w;
  logic signed [57:0] cs1_w;
  logic signed [39:0] cs1q_w, s_new_w;
  logic signed [79:0] pw_w;
  logic [31:0] tr_w;
  logic [10:0] tq_w, q_next;
  logic sq_ok_w, dv_ok_w;

  // Harmonic h lands on bin h*f0*N/rate, rounded
  assign bin_w = (32'(h_reg) * 32'(f0_reg) * ANA_LEN + SMP_RATE_HZ / 2) / SMP_RATE_HZ;
  assign cs1_w = coef_reg * s1_reg;
  assign cs1q_w = 40'(cs1_w >>> COEF_FRAC);
  assign s_new_w = 40'(rd_data_i) + cs1q_w - s2_reg;
  assign pw_w = s1_reg * s1_reg + s2_reg * s2_reg - cs1q_w * s2_reg;
  assign tr_w = root_reg | (32'h1 << bit_reg[4:0]);
  assign sq_ok_w = 64'(tr_w) * 64'(tr_w) <= pw_reg;
  assign tq_w = q_reg | 11'(32'h1 << bit_reg[3:0]);
  assign dv_ok_w = 48'(tq_w) * 48'(mag1_reg) <= 48'(root_reg) * 48'(PML_FULL);
  assign q_next = mag1_reg == 32'h0 ? 11'h000 : (dv_ok_w ? tq_w : q_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= S_IDLE;
      h_reg <= 5'h00;
      ord_reg <= 5'h00;
      f0_reg <= 11'h000;
      n_reg <= 11'h000;
      q_reg <= 11'h000;
      pml_reg <= 11'h000;
      bit_reg <= 6'h00;
      coef_reg <= 18'h00000;
      s1_reg <= 40'h0;
      s2_reg <= 40'h0;
      pw_reg <= 64'h0;
      root_reg <= 32'h0;
      mag1_reg <= 32'h0;
      we_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce_i) begin
      we_reg <= 1'b0;
      done_reg <= 1'b0;
      case (st_reg)
        S_IDLE: begin
          if (start_i) begin
            h_reg <= 5'h01;
            f0_reg <= f0_i;
            if (ord_ok(5'h01, f0_i)) begin // RULE_11
              st_reg <= S_COEF;
            end else begin
              done_reg <= 1'b1;
            end
          end
        end
        S_COEF: begin
          coef_reg <= wch_coef(bin_w[9:0]);
          s1_reg <= 40'h0;
          s2_reg <= 40'h0;
          n_reg <= 11'h000;
          st_reg <= S_RUN;
        end
        S_RUN: begin // RULE_09
          s2_reg <= s1_reg;
          s1_reg <= s_new_w;
          n_reg <= n_reg + 11'h001;
          if (n_reg == 11'(ANA_LEN - 1)) begin // RULE_10
            st_reg <= S_PWR;
          end
        end
        S_PWR: begin
          pw_reg <= pw_w < 0 ? 64'h0 : pw_w[63:0];
          root_reg <= 32'h0;
          bit_reg <= 6'd31;
          st_reg <= S_SQRT;
        end
        S_SQRT: begin
          if (sq_ok_w) begin
            root_reg <= tr_w;
          end
          if (bit_reg == 6'h00) begin
            if (h_reg == 5'h01) begin
              mag1_reg <= sq_ok_w ? tr_w : root_reg;
            end
            q_reg <= 11'h000;
            bit_reg <= 6'd10;
            st_reg <= S_DIV;
          end else begin
            bit_reg <= bit_reg - 6'h01;
          end
        end
        S_DIV: begin // RULE_14
          q_reg <= q_next;
          if (bit_reg == 6'h00) begin
            we_reg <= 1'b1;
            ord_reg <= h_reg;
            pml_reg <= q_next; // RULE_13
            h_reg <= h_reg + 5'h01;
            if (ord_ok(h_reg + 5'h01, f0_reg)) begin // RULE_11
              st_reg <= S_COEF;
            end else begin
              st_reg <= S_IDLE;
              done_reg <= 1'b1;
            end
          end else begin
            bit_reg <= bit_reg - 6'h01;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  assign busy_o = st_reg != S_IDLE;
  assign done_o = done_reg;
  assign rd_addr_o = n_reg[9:0];
  assign res_we_o = we_reg;
  assign res_order_o = ord_reg;
  assign res_pml_o = pml_reg;

  // ==========================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_order_limit: assert property (res_we_o |-> 32'(res_order_o) <= MAX_ORDER // RULE_11
    && 32'(res_order_o) * 32'(f0_reg) <= MAX_HARM_HZ) else $error("order past limit");
  a_fund_full: assert property (res_we_o && res_order_o == 5'h01 // RULE_14
    && mag1_reg != 32'h0 |-> res_pml_o == PML_FULL) else $error("fundamental not 100 pct");
  a_frame_len: assert property (ce_i && st_reg == S_COEF |=> // RULE_10
    st_reg == S_RUN && n_reg == 11'h000) else $error("frame walk not restarted");
endmodule

// ==== hw/wch_analyzer.sv ====
// Waveform capture, autoscale and harmonic analysis of a selected channel
//
// How it works
// RULE_01: Eighteen channels selectable for analysis.
// RULE_02: Per source: three Ph-N, three Ph-Ph, three currents.
// RULE_03: Mains currents offered only with load-side sensing.
// RULE_04: Display frame: 100 samples, 13 bits, 4096/s.
// RULE_05: Display trace auto-scaled, never clipping.
// RULE_06: Display frame refreshed twice per second.
// RULE_07: Display frame readable over fieldbus port.
// RULE_08: Channel-step input advances selected channel.
// RULE_09: Transform of selected channel twice per second.
// RULE_10: Analysis frame: 1024 samples, 13 bits, 4096/s.
// RULE_11: Orders up to 31 and 1800 Hz.
// RULE_12: Graph shows only harmonics above 2 percent.
// RULE_13: Table lists all harmonics in 0.1 percent.
// RULE_14: Magnitudes relative to channel fundamental.
// RULE_15: Frames published whole, never partially overwritten.
`timescale 1ns/1ps
module wch_analyzer (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Sampling front end
  input wch_pkg::wch_smp_s SMP_I,
  input wire logic [wch_pkg::F0_W-1:0] F0_I,
  input wire logic CT_LOAD_I,
  output logic [wch_pkg::CH_W-1:0] CHAN_O,
  // Operator
  input wire logic CHAN_STEP_I,
  // Display renderer
  input wire logic [wch_pkg::DA_W-1:0] DISP_ADDR_I,
  output logic signed [wch_pkg::SMP_W-1:0] DISP_DATA_O,
  output logic [3:0] DISP_SHIFT_O,
  output logic DISP_FRAME_O,
  input wire logic [wch_pkg::HA_W-1:0] HARM_ADDR_I,
  output wch_pkg::wch_harm_s HARM_O,
  output logic [wch_pkg::HA_W-1:0] HARM_MAX_O,
  output logic HARM_DONE_O,
  // Fieldbus readout
  input wire logic [wch_pkg::DA_W-1:0] BUS_ADDR_I,
  output logic signed [wch_pkg::SMP_W-1:0] BUS_DATA_O
);
  import wch_pkg::*;

  // ==========================================
  // Channel selection
  function automatic logic is_mains_i(input logic [4:0] c);
    return c >= CH_MAINS_I1 && c < CH_GEN_V1;
  endfunction

  function automatic logic [4:0] step_chan(input logic [4:0] c, input logic ct);
    logic [4:0] n;
    n = (c >= CH_LAST) ? CH_FIRST : c + 5'h01; // RULE_01
    if (!ct && is_mains_i(n)) begin // RULE_02
      n = CH_GEN_V1;
    end
    return n;
  endfunction

  logic [4:0] chan_reg, chan_next;
  logic chan_chg;

  // Sensing moved off the load side drops a mains current channel at once
  assign chan_next = CHAN_STEP_I ? step_chan(chan_reg, CT_LOAD_I) // RULE_08
    : (!CT_LOAD_I && is_mains_i(chan_reg)) ? CH_GEN_V1 : chan_reg; // RULE_03
  assign chan_chg = chan_next != chan_reg;
  assign CHAN_O = chan_reg;

  // ==========================================
  // Capture sequencing
  function automatic logic [11:0] abs_sat(input logic signed [12:0] x);
    return x[12] ? ((x == 13'h1000) ? FULL_SCALE : 12'(-x)) : x[11:0];
  endfunction

  function automatic logic [3:0] headroom(input logic [11:0] p);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (p[i]) begin
        s = 4'(11 - i);
      end
    end
    return s;
  endfunction

  logic [CNT_W-1:0] cnt_reg;
  logic dbank_reg, abank_reg, frame_reg;
  logic [11:0] peak_reg, peak_w;
  logic [3:0] shift_reg;
  logic smp_ok, disp_wr, ana_wr, disp_pub, ana_pub;
  logic h_busy, h_done, h_we;
  logic [AA_W-1:0] h_addr;
  logic [HA_W-1:0] h_order;
  logic [PML_W-1:0] h_pml;

  // A channel change restarts the frame so no capture mixes two channels
  assign smp_ok = SMP_I.vld && !chan_chg;
  assign disp_wr = smp_ok && cnt_reg < CNT_W'(DISP_LEN); // RULE_04
  assign ana_wr = smp_ok && cnt_reg < CNT_W'(ANA_LEN); // RULE_10
  assign disp_pub = smp_ok && cnt_reg == CNT_W'(DISP_LEN - 1); // RULE_06
  // A frame finishing while the analyser is busy is dropped, not swapped in
  assign ana_pub = smp_ok && cnt_reg == CNT_W'(ANA_LEN - 1) && !h_busy; // RULE_09
  assign peak_w = (cnt_reg == '0 || abs_sat(SMP_I.data) > peak_reg)
    ? abs_sat(SMP_I.data) : peak_reg;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      chan_reg <= CH_FIRST;
      cnt_reg <= '0;
      dbank_reg <= 1'b0;
      abank_reg <= 1'b0;
      peak_reg <= 12'h000;
      shift_reg <= 4'h0;
      frame_reg <= 1'b0;
    end else if (CE_I) begin
      chan_reg <= chan_next;
      frame_reg <= disp_pub;
      if (chan_chg) begin
        cnt_reg <= '0;
      end else if (SMP_I.vld) begin // RULE_06
        cnt_reg <= (cnt_reg == CNT_W'(UPDATE_SMP - 1)) ? '0 : cnt_reg + 1'b1;
      end
      if (disp_wr) begin
        peak_reg <= peak_w;
      end
      if (disp_pub) begin // RULE_15
        dbank_reg <= ~dbank_reg;
        shift_reg <= headroom(peak_w); // RULE_05
      end
      if (ana_pub) begin // RULE_15
        abank_reg <= ~abank_reg;
      end
    end
  end

  // ==========================================
  // Frame memories, filled behind the published bank
  logic signed [SMP_W-1:0] disp_mem [2][DISP_LEN];
  logic signed [SMP_W-1:0] ana_mem [2][ANA_LEN];

  always_ff @(posedge CLK_I) begin
    if (CE_I && disp_wr) begin
      disp_mem[~dbank_reg][cnt_reg[DA_W-1:0]] <= SMP_I.data; // RULE_15
    end
    if (CE_I && ana_wr) begin
      ana_mem[~abank_reg][cnt_reg[AA_W-1:0]] <= SMP_I.data; // RULE_15
    end
  end

  // ==========================================
  // Display and fieldbus readout
  logic signed [SMP_W-1:0] disp_q_reg, bus_q_reg;
  logic disp_in, bus_in;

  assign disp_in = DISP_ADDR_I < DA_W'(DISP_LEN);
  assign bus_in = BUS_ADDR_I < DA_W'(DISP_LEN);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      disp_q_reg <= 13'h0000;
      bus_q_reg <= 13'h0000;
    end else if (CE_I) begin
      disp_q_reg <= disp_in ? 13'(disp_mem[dbank_reg][DISP_ADDR_I] <<< shift_reg) // RULE_05
        : 13'h0000;
      bus_q_reg <= bus_in ? disp_mem[dbank_reg][BUS_ADDR_I] : 13'h0000; // RULE_07
    end
  end

  assign DISP_DATA_O = disp_q_reg;
  assign BUS_DATA_O = bus_q_reg;
  assign DISP_SHIFT_O = shift_reg;
  assign DISP_FRAME_O = frame_reg;

  // ==========================================
  // Harmonic analysis
  wch_harmonic u_harm (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .start_i(ana_pub),
    .f0_i(F0_I),
    .busy_o(h_busy),
    .done_o(h_done),
    .rd_addr_o(h_addr),
    .rd_data_i(ana_mem[abank_reg][h_addr]),
    .res_we_o(h_we),
    .res_order_o(h_order),
    .res_pml_o(h_pml)
  );

  // Results build in a work table and are published as a set
  logic [PML_W-1:0] hw_pml [MAX_ORDER+1];
  logic [PML_W-1:0] hp_pml [MAX_ORDER+1];
  logic [HA_W-1:0] hw_max_reg, hp_max_reg;
  wch_harm_s harm_reg;
  logic done_reg, h_valid;
  logic [PML_W-1:0] h_sel;

  assign h_valid = HARM_ADDR_I != '0 && HARM_ADDR_I <= hp_max_reg; // RULE_13
  assign h_sel = h_valid ? hp_pml[HARM_ADDR_I] : '0;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      hw_pml <= '{default: '0};
      hp_pml <= '{default: '0};
      hw_max_reg <= '0;
      hp_max_reg <= '0;
      harm_reg <= '0;
      done_reg <= 1'b0;
    end else if (CE_I) begin
      done_reg <= h_done;
      if (ana_pub) begin
        hw_max_reg <= '0;
      end else if (h_we) begin
        hw_pml[h_order] <= h_pml; // RULE_14
        hw_max_reg <= h_order;
      end
      if (h_done) begin // RULE_15
        hp_pml <= hw_pml;
        hp_max_reg <= hw_max_reg;
        // Last order lands in the done cycle, so it bypasses the work table
        if (h_we) begin
          hp_pml[h_order] <= h_pml;
          hp_max_reg <= h_order;
        end
      end
      harm_reg.valid <= h_valid;
      harm_reg.pml <= h_sel; // RULE_13
      harm_reg.show <= h_valid && h_sel > SHOW_MIN_PML; // RULE_12
    end
  end

  assign HARM_O = harm_reg;
  assign HARM_MAX_O = hp_max_reg;
  assign HARM_DONE_O = done_reg;

  // ==========================================
  // Checks
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_chan_range: assert property (CHAN_O <= CH_LAST) // RULE_01
    else $error("channel out of range");
  a_chan_step: assert property (CE_I && CHAN_STEP_I && CT_LOAD_I |=> // RULE_08
    CHAN_O == (($past(CHAN_O) == CH_LAST) ? CH_FIRST : $past(CHAN_O) + 5'h01))
    else $error("channel step wrong");
  a_ct_skip: assert property (CE_I && !CT_LOAD_I |=> !is_mains_i(CHAN_O)) // RULE_03
    else $error("mains current offered");
  a_gen_reach: assert property (CE_I && CHAN_STEP_I && !CT_LOAD_I // RULE_02
    && CHAN_O == 5'h05 |=> CHAN_O == CH_GEN_V1) else $error("group skip wrong");
  a_scale_fit: assert property (CE_I && disp_pub |=> // RULE_05
    (24'($past(peak_w)) << DISP_SHIFT_O) <= 24'(FULL_SCALE)) else $error("trace clips");
  a_disp_swap: assert property (CE_I && disp_pub |=> // RULE_15
    DISP_FRAME_O && dbank_reg != $past(dbank_reg)) else $error("display not swapped");
  a_ana_start: assert property (CE_I && ana_pub |=> h_busy ^ h_done) // RULE_09
    else $error("analysis not started");
  a_ana_full: assert property (ana_pub |-> cnt_reg == CNT_W'(ANA_LEN - 1)) // RULE_10
    else $error("partial analysis frame");
  a_show_min: assert property (HARM_O.show |-> HARM_O.valid // RULE_12
    && HARM_O.pml > SHOW_MIN_PML) else $error("small harmonic shown");

  c_disp_frame: cover property (DISP_FRAME_O);
  c_harm_done: cover property (HARM_DONE_O && HARM_MAX_O != '0);
  c_chan_wrap: cover property (CHAN_O == CH_LAST ##1 CHAN_O == CH_FIRST);
  c_show: cover property (HARM_O.show);
endmodule

// ==== test/wch_front_model.sv ====
// Sampling front end model: fundamental plus third harmonic at a set frequency
`timescale 1ns/1ps
module wch_front_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control from the bench
  input wire logic run_i,
  input wire logic signed [31:0] nsmp_i,
  input wire logic signed [31:0] a1_i,
  input wire logic signed [31:0] a3_i,
  input wire logic signed [31:0] f0_i,
  // Front end outputs
  output wch_pkg::wch_smp_s smp_o,
  output logic [wch_pkg::F0_W-1:0] f0_o,
  output int sent_o
);
  import wch_pkg::*;
  logic tog_reg;
  // ==========================================
  // Waveform
  function automatic logic signed [SMP_W-1:0] value(int n, int a1, int a3, int f);
    real w;
    real x;
    w = 2.0 * 3.14159265358979 * f * n / 4096.0;
    x = a1 * $sin(w) + a3 * $sin(3.0 * w);
    return SMP_W'($rtoi(x >= 0.0 ? x + 0.5 : x - 0.5));
  endfunction
  // ==========================================
  // Sample stream, one strobe every other cycle
  assign f0_o = f0_i[F0_W-1:0];
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      tog_reg <= 1'b0;
      sent_o <= 0;
      smp_o.vld <= 1'b0;
      smp_o.data <= rst_i ? 13'h0AAA : ~smp_o.data;
    end else if (sent_o < nsmp_i && !tog_reg) begin
      tog_reg <= 1'b1;
      smp_o.vld <= 1'b1;
      smp_o.data <= value(sent_o, a1_i, a3_i, f0_i);
    end else begin
      // Data line is not held between strobes, so stale values cannot pass
      tog_reg <= 1'b0;
      smp_o.vld <= 1'b0;
      smp_o.data <= ~smp_o.data;
      if (smp_o.vld) sent_o <= sent_o + 1;
    end
  end
endmodule

// ==== test/test_wch_analyzer.sv ====
// Self-checking bench for the waveform capture and harmonic analyser
`timescale 1ns/1ps
module test_wch_analyzer;
  import wch_pkg::*;
  // ==========================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic ct_load = 1'b1;
  logic chan_step = 1'b0;
  logic [DA_W-1:0] disp_addr = '0;
  logic [DA_W-1:0] bus_addr = '0;
  logic [HA_W-1:0] harm_addr = '0;
  wch_smp_s smp;
  logic [F0_W-1:0] f0;
  logic [CH_W-1:0] chan;
  logic signed [SMP_W-1:0] disp_data;
  logic signed [SMP_W-1:0] bus_data;
  logic [3:0] disp_shift;
  logic disp_frame;
  wch_harm_s harm;
  logic [HA_W-1:0] harm_max;
  logic harm_done;
  logic fe_run = 1'b0;
  int fe_n = 0, a1 = 0, a3 = 0, fw = 50, fe_sent;
  int num_errors = 0, n_tests = 0, cyc = 0;
  int shift_q[$], cnt_q[$], max_q[$];
  // ==========================================
  // Instances
  wch_analyzer wch_analyzer_i (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .SMP_I(smp), .F0_I(f0),
    .CT_LOAD_I(ct_load), .CHAN_O(chan), .CHAN_STEP_I(chan_step), .DISP_ADDR_I(disp_addr),
    .DISP_DATA_O(disp_data), .DISP_SHIFT_O(disp_shift), .DISP_FRAME_O(disp_frame),
    .HARM_ADDR_I(harm_addr), .HARM_O(harm), .HARM_MAX_O(harm_max), .HARM_DONE_O(harm_done),
    .BUS_ADDR_I(bus_addr), .BUS_DATA_O(bus_data));
  wch_front_model wch_front_model_i (.clk_i(clk), .rst_i(rst), .run_i(fe_run), .nsmp_i(fe_n),
    .a1_i(a1), .a3_i(a3), .f0_i(fw), .smp_o(smp), .f0_o(f0), .sent_o(fe_sent));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // Helpers
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("CHAN_O reset", chan, 0);
    check("HARM_MAX_O reset", harm_max, 0);
    check("DISP_SHIFT_O reset", disp_shift, 0);
    check("pulses reset", {harm_done, disp_frame}, 0);
  endtask
  function automatic logic [CH_W-1:0] next_chan(logic [CH_W-1:0] c, logic ct);
    logic [CH_W-1:0] n;
    n = (c == CH_LAST) ? CH_FIRST : c + 5'h01;
    if (!ct && n == CH_MAINS_I1) n = CH_GEN_V1;
    return n;
  endfunction
  task automatic step_chk();
    logic [CH_W-1:0] e;
    e = next_chan(chan, ct_load);
    @(posedge clk);
    chan_step <= 1'b1;
    @(posedge clk);
    chan_step <= 1'b0;
    #1;
    check("CHAN_O step", chan, e);
  endtask
  // Autoscale: leading headroom of the clamped 12-bit peak magnitude
  function automatic int exp_shift(int base);
    int pk;
    int v;
    int s;
    pk = 0;
    for (int k = 0; k < DISP_LEN; k++) begin
      v = wch_front_model_i.value(base + k, a1, a3, fw);
      if (v < 0) v = -v;
      if (v > pk) pk = v;
    end
    if (pk > 4095) pk = 4095;
    s = 0;
    while (s < 12 && pk < (2048 >> s)) s++;
    return s;
  endfunction
  task automatic capture(int n, int frames, int mx);
    int k;
    for (k = 0; k < frames; k++) begin
      shift_q.push_back(exp_shift(k * UPDATE_SMP));
      cnt_q.push_back(k * UPDATE_SMP + DISP_LEN);
    end
    if (mx >= 0) max_q.push_back(mx);
    @(posedge clk);
    fe_n <= n;
    fe_run <= 1'b1;
    for (k = 0; k < 45000 && mx >= 0 && harm_done !== 1'b1; k++) @(posedge clk);
    for (k = 0; k < 9000 && fe_sent < n; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    fe_run <= 1'b0;
  endtask
  task automatic rd_chk(int sh, logic [DA_W-1:0] a);
    logic signed [SMP_W-1:0] v;
    logic signed [SMP_W-1:0] dv;
    v = (a < DISP_LEN) ? wch_front_model_i.value(a, a1, a3, fw) : '0;
    dv = v <<< sh;
    @(posedge clk);
    disp_addr <= a;
    bus_addr <= a;
    @(posedge clk);
    #1;
    check("BUS_DATA_O", bus_data, v);
    check("DISP_DATA_O", disp_data, dv);
  endtask
  // ==========================================
  // Result monitor: oldest note against each published result, mid-cycle
  always @(negedge clk) begin
    if (disp_frame === 1'b1) begin
      if (shift_q.size() == 0) check("DISP_FRAME_O extra", 1, 0);
      else begin
        check("DISP_SHIFT_O", disp_shift, shift_q.pop_front());
        check("frame sample count", fe_sent, cnt_q.pop_front());
      end
    end
    if (harm_done === 1'b1) begin
      if (max_q.size() == 0) check("HARM_DONE_O extra", 1, 0);
      else check("HARM_MAX_O", harm_max, max_q.pop_front());
    end
  end
  // Hang guard; a full run needs about 51000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    int i, t, h, sh, mx, f;
    int lo[4];
    int freqs[4];
    lo = '{995, 0, 95, 0};
    freqs = '{400, 50, 900, 1801};
    void'($urandom(60533));
    do_reset();
    for (i = 0; i < 24; i++) step_chk();
    @(posedge clk);
    ce <= 1'b0;
    chan_step <= 1'b1;
    repeat (3) @(posedge clk);
    chan_step <= 1'b0;
    ce <= 1'b1;
    #1;
    check("CHAN_O frozen", chan, CH_MAINS_I1);
    @(posedge clk);
    ct_load <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("CHAN_O forced", chan, CH_GEN_V1);
    for (i = 0; i < 16; i++) step_chk();
    @(posedge clk);
    ct_load <= 1'b1;
    $display("channel test done");
    for (t = 0; t < 2; t++) begin
      do_reset();
      a1 = t ? 20 + $urandom % 236 : 100 + $urandom % 3000;
      a3 = t ? 0 : $urandom % 900;
      fw = 50;
      sh = exp_shift(0);
      capture(DISP_LEN, 1, -1);
      for (i = 0; i < 10; i++) begin
        rd_chk(sh, i == 0 ? 7'h00 : i == 1 ? 7'h63 : i == 2 ? 7'h64 : i == 3 ? 7'h7F :
          7'($urandom % DISP_LEN));
      end
      $display("display test done");
    end
    for (t = 0; t < 4; t++) begin
      do_reset();
      f = freqs[t];
      mx = 0;
      while (mx < MAX_ORDER && (mx + 1) * f <= MAX_HARM_HZ) mx++;
      a1 = 1500;
      a3 = 150;
      fw = f;
      capture(UPDATE_SMP + DISP_LEN, 2, mx);
      for (h = 0; h < 32; h++) begin
        @(posedge clk);
        harm_addr <= 5'(h);
        @(posedge clk);
        #1;
        check("HARM_O.valid", harm.valid, h >= 1 && h <= mx);
        if (f == 400 && h >= 1 && h <= 4) begin
          check("HARM_O.pml", harm.pml >= lo[h-1] && harm.pml <= lo[h-1] + 10, 1);
          check("HARM_O.show", harm.show, h % 2);
        end
      end
      $display("harmonic test done");
    end
    check("notes left", shift_q.size() + cnt_q.size() + max_q.size(), 0);
    report_and_stop();
  end
endmodule
